// ===== dv/mem_model.sv
`timescale 1ns/10ps
module mem_model
   import ext_bus_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              cfg_rd_strobe,
   input  wire logic [ADDR_W-1:0] cfg_rd_addr,
   input  wire logic              cycle_busy,
   input  wire logic [4:0]        waits,
   input  wire logic              alt,
   output logic      [CFG_W-1:0]  cfg_rd_data,
   output logic                   ready
);
   logic [CFG_W-1:0] data_q = 8'h00;
   logic [4:0]       cnt_q  = 5'h00;
   // Scrambled filler so a stale byte never passes
   always_ff @(posedge clk_sys) begin
      data_q <= ~data_q;
      cnt_q <= cycle_busy ? cnt_q - {4'h0, cnt_q != 5'h00} : waits;
   end
   // Byte served while the strobe stands: the block takes it at the edge ending the strobe
   // Width bits are never both zero in either byte set
   assign cfg_rd_data = !cfg_rd_strobe ? data_q :
                        (cfg_rd_addr == CCB0_ADDR) ? (alt ? 8'hdd : 8'hdf) :
                        (cfg_rd_addr == CCB1_ADDR) ? 8'h86 : 8'h5a;
   // Slow device holds ready low until its access time runs out
   assign ready       = (cnt_q == 5'h00);
endmodule : mem_model

// ===== dv/tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
`define WAITFOR(c, n) begin for (i = 0; i < n && !(c); i++) tick(); \
   if (!(c)) begin num_errors++; $display("ERROR wait expected 1 seen 0"); conclude(); end end
module tb;
   import ext_bus_pkg::*;
   logic              clk_sys = 1'b0, sys_rst = 1'b1, reset_n_pin = 1'b0, nmi_pin = 1'b0;
   logic              ext_sel = 1'b1, prog_lvl = 1'b0, mult_sel = 1'b1, alt = 1'b0;
   logic              bus_cycle_start = 1'b0, access_internal_other = 1'b0;
   logic [ADDR_W-1:0] mem_addr = 24'h000000;
   logic [7:0]        pins = 8'h00, gpio_out = 8'h00, gpio_oe = 8'h00;
   logic [4:0]        waits = 5'h00;
   logic [CFG_W-1:0]  cfg_rd_data, chip_config_reg0, chip_config_reg1, chip_config_reg2;
   logic [ADDR_W-1:0] cfg_rd_addr, jump_addr, nmi_vector_addr;
   logic              cfg_rd_strobe, jump_valid, nmi_vector_valid, prog_mode, pll_bypass;
   logic              onchip_select, cycle_busy, cycle_done, cycle_16bit, wait_active, ready;
   logic              core_reset, width_illegal;
   logic [2:0]        clk_mult_ratio;
   logic [7:0]        shared_pin_out, shared_pin_oe, gpio_in, sys_in;
   int                num_errors = 0, n_compared = 0, i, wa;
   // Slot 0 is ready from the slow device, slot 1 bus width
   wire logic [7:0]   shared_pin_in = {pins[7:1], ready};

   ext_bus_boot_wait_ctrl i_dut (.clk_sys, .sys_rst, .reset_n_pin, .nmi_pin,
      .external_access_select(ext_sel), .prog_voltage_seen(prog_lvl),
      .clock_multiplier_select(mult_sel),
      .clock_output(), .core_reset, .psw_clear(), .cfg_rd_strobe, .cfg_rd_addr,
      .cfg_rd_data, .jump_valid, .jump_addr, .nmi_vector_valid, .nmi_vector_addr, .prog_mode,
      .pll_bypass, .clk_mult_ratio, .chip_config_reg0, .chip_config_reg1, .chip_config_reg2,
      .mem_addr, .onchip_select, .bus_cycle_start, .access_internal_other, .cycle_busy,
      .cycle_done, .cycle_16bit, .wait_active, .width_illegal, .sys_func_sel(8'h03),
      .sys_out(~gpio_out), .sys_oe(gpio_oe), .gpio_out, .gpio_oe, .shared_pin_in,
      .shared_pin_out, .shared_pin_oe, .gpio_in, .sys_in);
   mem_model i_mem (.clk_sys, .cfg_rd_strobe, .cfg_rd_addr, .cycle_busy, .waits, .alt,
      .cfg_rd_data, .ready);

   // Clock at 10 MHz
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude

   task automatic t_boot;
      `WAITFOR(jump_valid === 1'b1, 300)
      `CHK("jump_addr", START_ADDR, jump_addr)
      `CHK("core_reset", 1'b0, core_reset)
      `CHK("illegal", 1'b0, width_illegal)
      `CHK("cfg0", alt ? 8'hdd : 8'hdf, chip_config_reg0)
      `CHK("cfg1", 8'h86, chip_config_reg1)
      `CHK("cfg2", 8'h5a, chip_config_reg2)
      `CHK("prog_mode", prog_lvl, prog_mode)
      `CHK("pll_bypass", !mult_sel, pll_bypass)
      `CHK("ratio", mult_sel ? MULT_PLL : MULT_BYPASS, clk_mult_ratio)
      $display("boot test done");
   endtask : t_boot

   task automatic t_range;
      logic [ADDR_W-1:0] a [3] = '{24'hff1fff, ONCHIP_LO, ONCHIP_HI};
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_sys) mem_addr <= a[k];
         tick();
         `CHK("onchip", ext_sel && k != 0, onchip_select)
      end
      $display("range test done");
   endtask : t_range

   task automatic t_nmi;
      @(posedge clk_sys) nmi_pin <= 1'b1;
      `WAITFOR(nmi_vector_valid === 1'b1, 8)
      `CHK("nmi_addr", NMI_VEC_ADDR, nmi_vector_addr)
      tick();
      `CHK("nmi_pulse", 1'b0, nmi_vector_valid)
      @(posedge clk_sys) nmi_pin <= 1'b0;
      $display("nmi test done");
   endtask : t_nmi

   // Limit of 2 wait states comes from the model's config bytes
   task automatic t_cycle(input logic ext, input logic [4:0] w, input logic bw, input int lim);
      @(posedge clk_sys) begin
         waits <= w;
         pins[1] <= bw;
         access_internal_other <= !ext;
         mem_addr <= 24'h010000; // Plain external space, never on-chip
      end
      repeat (4) tick();
      @(posedge clk_sys) bus_cycle_start <= 1'b1;
      @(posedge clk_sys) bus_cycle_start <= 1'b0;
      wa = 0;
      for (i = 0; i < lim && cycle_done !== 1'b1; i++) begin
         tick();
         wa += int'(wait_active === 1'b1);
      end
      `CHK("done", 1'b1, cycle_done)
      `CHK("width16", bw && !alt, cycle_16bit)
      `CHK("waited", ext && w != 5'h00, wa != 0)
      repeat (2) tick();
      $display("cycle test done");
   endtask : t_cycle

   task automatic t_gpio;
      @(posedge clk_sys) begin
         gpio_out <= 8'h80;
         gpio_oe <= 8'h80;
         pins[7] <= 1'b1;
      end
      // Pin input needs two sync flops plus the output register
      repeat (3) tick();
      `CHK("gpio_pin", 8'h80, shared_pin_out & 8'h80)
      `CHK("gpio_oe", 8'h80, shared_pin_oe & 8'h80)
      `CHK("gpio_in", 8'h80, gpio_in & 8'h83)
      `CHK("sys_in", 8'h00, sys_in & 8'h80)
      $display("gpio test done");
   endtask : t_gpio

   // Second pin reset in mid-run; straps turned over and the other byte set served
   task automatic t_strap;
      @(posedge clk_sys) begin
         reset_n_pin <= 1'b0;
         ext_sel <= 1'b0;
         prog_lvl <= 1'b1;
         mult_sel <= 1'b0;
         alt <= 1'b1;
      end
      repeat (40) tick();
      `CHK("core_reset", 1'b1, core_reset)
      @(posedge clk_sys) reset_n_pin <= 1'b1;
      t_boot();
      $display("strap test done");
   endtask : t_strap

   // Main sequence; pin reset held past sixteen state times
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (40) @(posedge clk_sys);
      reset_n_pin <= 1'b1;
      t_boot();
      t_range();
      t_nmi();
      t_cycle(1'b1, 5'h00, 1'b1, 5);
      t_cycle(1'b1, 5'h14, 1'b0, 14);
      t_cycle(1'b0, 5'h14, 1'b1, 5);
      t_gpio();
      t_strap();
      t_range();
      t_cycle(1'b1, 5'h14, 1'b1, 14);
      conclude();
   end
endmodule : tb

// ===== verilog/bus_cycle_ctrl.sv
`timescale 1ns/10ps
module bus_cycle_ctrl
   import ext_bus_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             co_fall,
   input  wire logic             co_rise,
   input  wire logic             cycle_start,
   input  wire logic             cycle_external,
   input  wire logic [CFG_W-1:0] chip_config_reg0,
   input  wire logic [CFG_W-1:0] chip_config_reg1,
   input  wire logic             ready_s,
   input  wire logic             ready_sel,
   input  wire logic             bus_width_s,
   output logic                  cycle_busy,
   output logic                  cycle_done,
   output logic                  cycle_16bit,
   output logic                  wait_active,
   output logic                  width_illegal
);
   typedef struct packed {
      cycle_state_type st;
      logic            ext;
      logic [1:0]      limit;
      logic            inf;
      logic [1:0]      wcnt;
      logic            w16;
      logic            illegal;
   } cyc_st_type;

   cyc_st_type q, d;
   logic [2:0] lim;
   logic [1:0] mode;
   logic       w16_now;

   assign lim  = wait_limit(chip_config_reg0, chip_config_reg1);
   assign mode = bw_mode(chip_config_reg0, chip_config_reg1);

   // Width of the cycle in progress; illegal setting falls back to 8-bit
   always_comb begin
      unique case (mode)
         BW_PIN:  w16_now = bus_width_s;
         BW_16:   w16_now = 1'b1;
         default: w16_now = 1'b0;
      endcase
   end

   // Cycle sequencing and wait-state insertion
   always_comb begin
      d         = q;
      d.illegal = (mode == BW_ILLEGAL);
      unique case (q.st)
         C_IDLE: if (cycle_start) begin
            d.st    = C_ACT;
            d.ext   = cycle_external;
            d.inf   = lim[2];
            d.limit = lim[1:0];
            d.wcnt  = 2'h0;
            d.w16   = w16_now;
         end
         C_ACT: begin
            d.w16 = w16_now;
            if (co_fall) begin
               // Ready only counts on external cycles with its pin function chosen
               if (q.ext && ready_sel && !ready_s && (q.inf || q.limit != 2'h0)) begin
                  d.st = C_WAIT;
               end else begin
                  d.st = C_END;
               end
            end
         end
         C_WAIT: begin
            d.w16 = w16_now;
            if (co_rise) begin
               d.wcnt = q.wcnt + 2'h1;
               if (ready_s || (!q.inf && (q.wcnt + 2'h1) == q.limit)) begin
                  d.st = C_END;
               end
            end
         end
         C_END: d.st = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '{st: C_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign cycle_busy    = (q.st != C_IDLE);
   assign cycle_done    = (q.st == C_END);
   assign wait_active   = (q.st == C_WAIT);
   assign cycle_16bit   = q.w16;
   assign width_illegal = q.illegal;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_stall;
      q.st == C_ACT && co_fall && q.ext && ready_sel && !ready_s && q.limit != 2'h0;
   endsequence

   property p_bw_pin;
      (q.st == C_ACT || q.st == C_WAIT) && mode == BW_PIN |=> cycle_16bit == $past(bus_width_s);
   endproperty
   a_bw_pin: assert property (p_bw_pin) else $error("bus width pin not followed");

   property p_bw_fixed;
      q.st == C_ACT && (mode == BW_8 || mode == BW_16) |=> cycle_16bit == $past(mode == BW_16);
   endproperty
   a_bw_fixed: assert property (p_bw_fixed) else $error("fixed bus width wrong");

   property p_wait_enter;
      s_stall |=> wait_active;
   endproperty
   a_wait_enter: assert property (p_wait_enter) else $error("no wait on low ready");

   property p_wait_exit;
      wait_active && co_rise && ready_s |=> cycle_done ##1 !cycle_busy;
   endproperty
   a_wait_exit: assert property (p_wait_exit) else $error("wait not ended by ready");

   property p_wait_limit;
      q.st == C_WAIT && !q.inf |-> q.wcnt < q.limit;
   endproperty
   a_wait_limit: assert property (p_wait_limit) else $error("wait count above limit");

   property p_no_ready_internal;
      q.st == C_ACT && co_fall && !q.ext |=> cycle_done;
   endproperty
   a_no_ready_internal: assert property (p_no_ready_internal) else $error("internal cycle stalled");
endmodule : bus_cycle_ctrl

// ===== verilog/ext_bus_boot_wait_ctrl.sv
`timescale 1ns/10ps
module ext_bus_boot_wait_ctrl
   import ext_bus_pkg::*;
#(
   parameter int NUM_SHARED_PINS = 8
) (
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   input  wire logic                       reset_n_pin,
   input  wire logic                       nmi_pin,
   input  wire logic                       external_access_select,
   input  wire logic                       prog_voltage_seen,
   input  wire logic                       clock_multiplier_select,
   output logic                            clock_output,
   output logic                            core_reset,
   output logic                            psw_clear,
   output logic                            cfg_rd_strobe,
   output logic [ext_bus_pkg::ADDR_W-1:0]  cfg_rd_addr,
   input  wire logic [ext_bus_pkg::CFG_W-1:0] cfg_rd_data,
   output logic                            jump_valid,
   output logic [ext_bus_pkg::ADDR_W-1:0]  jump_addr,
   output logic                            nmi_vector_valid,
   output logic [ext_bus_pkg::ADDR_W-1:0]  nmi_vector_addr,
   output logic                            prog_mode,
   output logic                            pll_bypass,
   output logic [2:0]                      clk_mult_ratio,
   output logic [ext_bus_pkg::CFG_W-1:0]   chip_config_reg0,
   output logic [ext_bus_pkg::CFG_W-1:0]   chip_config_reg1,
   output logic [ext_bus_pkg::CFG_W-1:0]   chip_config_reg2,
   input  wire logic [ext_bus_pkg::ADDR_W-1:0] mem_addr,
   output logic                            onchip_select,
   input  wire logic                       bus_cycle_start,
   input  wire logic                       access_internal_other,
   output logic                            cycle_busy,
   output logic                            cycle_done,
   output logic                            cycle_16bit,
   output logic                            wait_active,
   output logic                            width_illegal,
   input  wire logic [NUM_SHARED_PINS-1:0] sys_func_sel,
   input  wire logic [NUM_SHARED_PINS-1:0] sys_out,
   input  wire logic [NUM_SHARED_PINS-1:0] sys_oe,
   input  wire logic [NUM_SHARED_PINS-1:0] gpio_out,
   input  wire logic [NUM_SHARED_PINS-1:0] gpio_oe,
   input  wire logic [NUM_SHARED_PINS-1:0] shared_pin_in,
   output logic      [NUM_SHARED_PINS-1:0] shared_pin_out,
   output logic      [NUM_SHARED_PINS-1:0] shared_pin_oe,
   output logic      [NUM_SHARED_PINS-1:0] gpio_in,
   output logic      [NUM_SHARED_PINS-1:0] sys_in
);
   localparam int N     = NUM_SHARED_PINS;
   localparam int LOW_W = $clog2(RESET_MIN_STATES + 1);
   localparam logic [LOW_W-1:0] LOW_MAX = LOW_W'(RESET_MIN_STATES);

   // Ready and bus width must live inside the shared-pin vector
   if (N <= SP_READY || N <= SP_BUS_WIDTH) begin : g_bad_pins
      $error("NUM_SHARED_PINS too small for ready and bus width slots");
   end

   typedef struct packed {
      boot_state_type    boot;
      logic              co;
      logic [LOW_W-1:0]  low_cnt;
      logic              held;
      logic              rst_prev;
      logic [STEP_W-1:0] step;
      logic              ext_acc;
      logic              prog;
      logic              mult;
      logic [CFG_W-1:0]  cfg0;
      logic [CFG_W-1:0]  cfg1;
      logic [CFG_W-1:0]  cfg2;
      logic [1:0]        rd_sel;
      logic              psw_clr;
      logic              rd_stb;
      logic [ADDR_W-1:0] rd_addr;
      logic              jump;
      logic [ADDR_W-1:0] jaddr;
      logic              nmi_prev;
      logic              nmi_vec;
      logic [ADDR_W-1:0] naddr;
      logic              onchip;
      logic [N-1:0]      pin_out;
      logic [N-1:0]      pin_oe;
      logic [N-1:0]      gpio_in;
      logic [N-1:0]      sys_in;
   } top_st_type;

   top_st_type q, d;

   logic [N+4:0] raw_pins;
   logic [N+4:0] pins_s;
   logic [N-1:0] shared_s;
   logic         rst_s;
   logic         nmi_s;
   logic         xsel_s;
   logic         prog_s;
   logic         mult_s;
   logic         cyc_ext;

   // Every pin is asynchronous to clk_sys, so all pass two flops
   assign raw_pins = {clock_multiplier_select, prog_voltage_seen, external_access_select,
                      nmi_pin, reset_n_pin, shared_pin_in};

   pin_sync #(.WIDTH(N + 5)) u_pin_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (raw_pins),
      .sync_out (pins_s)
   );

   assign shared_s = pins_s[N-1:0];
   assign rst_s    = pins_s[N];
   assign nmi_s    = pins_s[N+1];
   assign xsel_s   = pins_s[N+2];
   assign prog_s   = pins_s[N+3];
   assign mult_s   = pins_s[N+4];

   // Accesses outside the on-chip range or other internal space use the pins
   assign cyc_ext = !(q.ext_acc && in_onchip_range(mem_addr)) && !access_internal_other;

   // Reset timing, start sequence, straps, NMI edge and pin muxing
   always_comb begin
      d          = q;
      d.psw_clr  = 1'b0;
      d.rd_stb   = 1'b0;
      d.jump     = 1'b0;
      d.nmi_vec  = 1'b0;
      d.co       = ~q.co;
      d.rst_prev = rst_s;

      // Straps are sampled all through reset; last value before release sticks
      if (q.boot == B_RESET) begin
         d.ext_acc = xsel_s;
         d.prog = prog_s;
         d.mult = mult_s;
      end

      // Config byte arrives in the same cycle as its strobe
      if (q.rd_stb) begin
         unique case (q.rd_sel)
            2'h0:    d.cfg0 = cfg_rd_data;
            2'h1:    d.cfg1 = cfg_rd_data;
            default: d.cfg2 = cfg_rd_data;
         endcase
      end

      unique case (q.boot)
         B_RESET: begin
            if (q.held && rst_s && !q.rst_prev) begin
               d.boot    = B_SEQ;
               d.held    = 1'b0;
               d.co      = 1'b0;
               d.step    = '0;
               d.psw_clr = 1'b1;
            end
         end
         B_SEQ: begin
            if (q.co) begin
               d.step = q.step + 4'h1;
               if (q.step == STEP_LAST) begin
                  d.boot  = B_RUN;
                  d.jump  = 1'b1;
                  d.jaddr = START_ADDR;
               end else if (d.step == STEP_CCB0) begin
                  d.rd_stb  = 1'b1;
                  d.rd_addr = CCB0_ADDR;
                  d.rd_sel  = 2'h0;
               end else if (d.step == STEP_CCB1) begin
                  d.rd_stb  = 1'b1;
                  d.rd_addr = CCB1_ADDR;
                  d.rd_sel  = 2'h1;
               end else if (d.step == STEP_CCB2 && q.cfg1[REG1_CCB2EN_BIT]) begin
                  d.rd_stb  = 1'b1;
                  d.rd_addr = CCB2_ADDR;
                  d.rd_sel  = 2'h2;
               end
            end
         end
         B_RUN: begin
            // NMI ignored until the start sequence has finished
            if (nmi_s && !q.nmi_prev) begin
               d.nmi_vec = 1'b1;
               d.naddr   = NMI_VEC_ADDR;
            end
         end
      endcase
      d.nmi_prev = nmi_s;

      // Low time counted in state times; a short pulse is ignored
      if (rst_s) begin
         d.low_cnt = '0;
      end else if (!q.co && q.low_cnt != LOW_MAX) begin
         d.low_cnt = q.low_cnt + 1'b1;
      end
      if (!rst_s && d.low_cnt == LOW_MAX) begin
         d.held = 1'b1;
         d.boot = B_RESET;
      end

      d.onchip = q.ext_acc && in_onchip_range(mem_addr);

      // Unselected pins fall back to GPIO
      d.pin_out = (sys_func_sel & sys_out) | (~sys_func_sel & gpio_out);
      d.pin_oe  = (sys_func_sel & sys_oe) | (~sys_func_sel & gpio_oe);
      d.gpio_in = shared_s & ~sys_func_sel;
      d.sys_in  = shared_s & sys_func_sel;
   end

   // A sys_rst counts as a completed pin reset; release waits for the pin high
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '{boot: B_RESET, held: 1'b1, cfg0: CFG_RESET, cfg1: CFG_RESET,
                cfg2: CFG_RESET, default: '0};
      end else begin
         q <= d;
      end
   end

   bus_cycle_ctrl u_bus_cycle (
      .clk_sys          (clk_sys),
      .sys_rst          (sys_rst),
      .co_fall          (q.co),
      .co_rise          (~q.co),
      .cycle_start      (bus_cycle_start && q.boot == B_RUN),
      .cycle_external   (cyc_ext),
      .chip_config_reg0 (q.cfg0),
      .chip_config_reg1 (q.cfg1),
      .ready_s          (shared_s[SP_READY]),
      .ready_sel        (sys_func_sel[SP_READY]),
      .bus_width_s      (shared_s[SP_BUS_WIDTH]),
      .cycle_busy       (cycle_busy),
      .cycle_done       (cycle_done),
      .cycle_16bit      (cycle_16bit),
      .wait_active      (wait_active),
      .width_illegal    (width_illegal)
   );

   // Output mapping
   assign clock_output     = q.co;
   assign core_reset       = (q.boot != B_RUN);
   assign psw_clear        = q.psw_clr;
   assign cfg_rd_strobe    = q.rd_stb;
   assign cfg_rd_addr      = q.rd_addr;
   assign jump_valid       = q.jump;
   assign jump_addr        = q.jaddr;
   assign nmi_vector_valid = q.nmi_vec;
   assign nmi_vector_addr  = q.naddr;
   assign prog_mode        = q.prog;
   assign pll_bypass       = ~q.mult;
   assign clk_mult_ratio   = q.mult ? MULT_PLL : MULT_BYPASS;
   assign chip_config_reg0 = q.cfg0;
   assign chip_config_reg1 = q.cfg1;
   assign chip_config_reg2 = q.cfg2;
   assign onchip_select    = q.onchip;
   assign shared_pin_out   = q.pin_out;
   assign shared_pin_oe    = q.pin_oe;
   assign gpio_in          = q.gpio_in;
   assign sys_in           = q.sys_in;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_release;
      q.boot == B_RESET && q.held && rst_s && !q.rst_prev;
   endsequence

   sequence s_leave_reset;
      q.boot == B_RESET ##1 q.boot == B_SEQ;
   endsequence

   property p_boot_seq;
      s_release |=> psw_clear && !clock_output
         ##4 (cfg_rd_strobe && cfg_rd_addr == CCB0_ADDR)
         ##4 (cfg_rd_strobe && cfg_rd_addr == CCB1_ADDR)
         ##12 (jump_valid && jump_addr == START_ADDR && !core_reset);
   endproperty
   a_boot_seq: assert property (p_boot_seq) else $error("start sequence out of step");

   property p_nmi_vector;
      q.boot == B_RUN && $rose(nmi_s) |=> nmi_vector_valid && nmi_vector_addr == NMI_VEC_ADDR;
   endproperty
   a_nmi_vector: assert property (p_nmi_vector) else $error("NMI edge not vectored");

   property p_onchip_map;
      1'b1 |=> onchip_select == ($past(q.ext_acc) && in_onchip_range($past(mem_addr)));
   endproperty
   a_onchip_map: assert property (p_onchip_map) else $error("on-chip select wrong");

   property p_strap_latched;
      q.boot == B_RUN |=> $stable(q.ext_acc) && $stable(prog_mode) && $stable(pll_bypass);
   endproperty
   a_strap_latched: assert property (p_strap_latched) else $error("strap changed after reset");

   property p_prog_strap;
      s_leave_reset |-> prog_mode == $past(prog_s);
   endproperty
   a_prog_strap: assert property (p_prog_strap) else $error("programming mode not latched");

   property p_mult_strap;
      s_leave_reset |-> pll_bypass == !$past(mult_s) &&
                        clk_mult_ratio == ($past(mult_s) ? MULT_PLL : MULT_BYPASS);
   endproperty
   a_mult_strap: assert property (p_mult_strap) else $error("multiplier strap wrong");

   property p_gpio_fallback;
      1'b1 |=> (gpio_in & $past(sys_func_sel)) == '0 &&
               (shared_pin_oe & ~$past(sys_func_sel)) == ($past(gpio_oe) & ~$past(sys_func_sel));
   endproperty
   a_gpio_fallback: assert property (p_gpio_fallback) else $error("GPIO fallback wrong");
endmodule : ext_bus_boot_wait_ctrl

// ===== verilog/ext_bus_pkg.sv
package ext_bus_pkg;

   // Clock and state-time figures
   localparam int CLK_PERIOD_NS    = 100;
   localparam int CLKS_PER_STATE   = 2;
   localparam int RESET_MIN_STATES = 16;
   localparam int BOOT_STATES      = 10;
   localparam int STEP_W           = 4;
   localparam int ADDR_W           = 24;
   localparam int CFG_W            = 8;

   // Fixed addresses of the start sequence, the NMI vector and on-chip program space
   localparam logic [ADDR_W-1:0] CCB0_ADDR    = 24'h002018;
   localparam logic [ADDR_W-1:0] CCB1_ADDR    = 24'h00201a;
   localparam logic [ADDR_W-1:0] CCB2_ADDR    = 24'h00201c;
   localparam logic [ADDR_W-1:0] START_ADDR   = 24'h002080;
   localparam logic [ADDR_W-1:0] NMI_VEC_ADDR = 24'h00203e;
   localparam logic [ADDR_W-1:0] ONCHIP_LO    = 24'hff2000;
   localparam logic [ADDR_W-1:0] ONCHIP_HI    = 24'hffffff;

   // Start-sequence state times at which each action fires
   localparam logic [STEP_W-1:0] STEP_CCB0 = 4'h2;
   localparam logic [STEP_W-1:0] STEP_CCB1 = 4'h4;
   localparam logic [STEP_W-1:0] STEP_CCB2 = 4'h6;
   localparam logic [STEP_W-1:0] STEP_LAST = 4'h9;

   // Field positions in the configuration registers
   localparam int REG0_BW_BIT     = 1;
   localparam int REG1_BW_BIT     = 2;
   localparam int REG0_IRC0_BIT   = 4;
   localparam int REG0_IRC1_BIT   = 5;
   localparam int REG1_IRC2_BIT   = 1;
   localparam int REG1_CCB2EN_BIT = 7;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'hff;

   // Bus width modes, coded {reg1 bit, reg0 bit}
   localparam logic [1:0] BW_ILLEGAL = 2'h0;
   localparam logic [1:0] BW_16      = 2'h1;
   localparam logic [1:0] BW_8       = 2'h2;
   localparam logic [1:0] BW_PIN     = 2'h3;

   // Clock multiplier ratios
   localparam logic [2:0] MULT_BYPASS = 3'h1;
   localparam logic [2:0] MULT_PLL    = 3'h4;

   // Shared-pin slots that carry ready and bus width
   localparam int SP_READY     = 0;
   localparam int SP_BUS_WIDTH = 1;

   typedef enum logic [1:0] {B_RESET, B_SEQ, B_RUN} boot_state_type;
   typedef enum logic [1:0] {C_IDLE, C_ACT, C_WAIT, C_END} cycle_state_type;

   function automatic logic in_onchip_range(input logic [ADDR_W-1:0] a);
      return (a >= ONCHIP_LO) && (a <= ONCHIP_HI);
   endfunction : in_onchip_range

   function automatic logic [1:0] bw_mode(input logic [CFG_W-1:0] c0,
                                          input logic [CFG_W-1:0] c1);
      return {c1[REG1_BW_BIT], c0[REG0_BW_BIT]};
   endfunction : bw_mode

   // Returns {infinite, limit}; unlisted codes give zero wait states
   function automatic logic [2:0] wait_limit(input logic [CFG_W-1:0] c0,
                                             input logic [CFG_W-1:0] c1);
      logic [2:0] irc;
      irc = {c1[REG1_IRC2_BIT], c0[REG0_IRC1_BIT], c0[REG0_IRC0_BIT]};
      unique case (irc)
         3'h4:    return 3'h1;
         3'h5:    return 3'h2;
         3'h6:    return 3'h3;
         3'h7:    return 3'h4;
         default: return 3'h0;
      endcase
   endfunction : wait_limit

endpackage : ext_bus_pkg

// ===== verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_st_type;

   sync_st_type q, d;

   // First stage feeds only the second
   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;
endmodule : pin_sync
